// File: servo_cmd_cfg.svh
// constants for the pulse position command front end
// assumes a 20 MHz drive clock and APB register access
`ifndef SERVO_CMD_CFG_SVH
`define SERVO_CMD_CFG_SVH

// ====================================================================
// register byte offsets
`define OFS_MODE_CFG       8'h00
`define OFS_GEAR_NUM1      8'h04
`define OFS_GEAR_DEN       8'h08
`define OFS_GEAR_NUM2      8'h0C
`define OFS_CMD_SMOOTH     8'h10
`define OFS_POS_GAIN       8'h14
`define OFS_FF_GAIN        8'h18
`define OFS_FF_SMOOTH      8'h1C
`define OFS_ERR_LIMIT      8'h20
`define OFS_FUNC_WORD      8'h24
`define OFS_STATUS         8'h28
`define OFS_POS_CMD        8'h2C

// ====================================================================
// mode_cfg field positions, and the function word internal enable bit
`define BIT_INVERT         2
`define BIT_DYN_GEAR       3
`define BIT_PROHIBIT_SEL   4
`define BIT_INT_ENABLE     0

// ====================================================================
// reset values and limits
`define RST_GEAR           15'h0001
`define RST_POS_GAIN       10'h032
`define RST_ERR_LIMIT      15'h0190
`define MAX_POS_GAIN       10'h3E8
`define MAX_FF_GAIN        7'h64
`define MAX_SMOOTH         15'h7530
`define MAX_FF_SMOOTH      10'h3E8

// ====================================================================
// timing
`define CLK_PERIOD_NS      50
`define CMD_TICK_NS        100000
`define FF_TICK_NS         1000000
`define CMD_TICK_CYC       (`CMD_TICK_NS / `CLK_PERIOD_NS)
`define FF_TICK_CYC        (`FF_TICK_NS / `CLK_PERIOD_NS)

`endif

// File: servo_cmd_pkg.sv
// types shared by the pulse command front end
// assumes nothing beyond the tool
package servo_cmd_pkg;

    // ================================================================
    // pulse input formats
    typedef enum logic [1:0] {
        FMT_PULSE_DIR = 2'b00,
        FMT_CW_CCW    = 2'b01,
        FMT_QUAD      = 2'b10
    } pulse_fmt_t;

endpackage : servo_cmd_pkg

// File: pulse_decode.sv
// decodes the synchronised pulse and sign lines into count steps
// assumes both lines already passed a two-stage synchroniser
`timescale 1ns/1ps
module pulse_decode
    import servo_cmd_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // configuration
    input  wire pulse_fmt_t fmt_i,
    input  wire logic       invert_i,
    // synchronised lines
    input  wire logic       pulse_i,
    input  wire logic       sign_i,
    // decoded step
    output logic            step_o,
    output logic            dir_o
);

    logic pulse_d_r;
    logic sign_d_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pulse_d_r <= 1'b0;
            sign_d_r  <= 1'b0;
        end else begin
            pulse_d_r <= pulse_i;
            sign_d_r  <= sign_i;
        end
    end

    wire pulse_rise = pulse_i & ~pulse_d_r;
    wire sign_rise  = sign_i & ~sign_d_r;
    wire a_edge     = pulse_i ^ pulse_d_r;
    wire b_edge     = sign_i ^ sign_d_r;
    // quadrature: reverse when the edge line equals the other line after an a edge
    wire quad_rev   = a_edge ? (pulse_i == sign_i) : (pulse_i != sign_i);
    // dir 1 means reverse count
    wire raw_dir    = (fmt_i == FMT_PULSE_DIR) ? sign_i :
                      (fmt_i == FMT_CW_CCW)    ? ~pulse_rise :
                                                 quad_rev;
    assign step_o = (fmt_i == FMT_PULSE_DIR) ? pulse_rise :
                    (fmt_i == FMT_CW_CCW)    ? (pulse_rise ^ sign_rise) :
                    (fmt_i == FMT_QUAD)      ? (a_edge ^ b_edge) : 1'b0;
    assign dir_o  = raw_dir ^ invert_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_fmt0_dir;
        (fmt_i == FMT_PULSE_DIR) && pulse_i && !pulse_d_r |-> step_o && dir_o == (sign_i ^ invert_i);
    endproperty
    a_fmt0_dir: assert property (p_fmt0_dir) else $error("pulse-dir step wrong");

    property p_fmt1_rev;
        (fmt_i == FMT_CW_CCW) && sign_i && !sign_d_r && !(pulse_i && !pulse_d_r)
            |-> step_o && dir_o == ~invert_i;
    endproperty
    a_fmt1_rev: assert property (p_fmt1_rev) else $error("reverse train step wrong");

    c_quad_step: cover property ((fmt_i == FMT_QUAD) && step_o);

endmodule : pulse_decode

// File: servo_pulse_position_command.sv
// position command front end: pulse decode, gearing, smoothing, settings
// assumes an APB master on clk_i and asynchronous pins for the pulse,
// sign, enable, prohibit and gear select inputs
//
// Behaviour
// - pins: pulse and sign pairs, enable, prohibit, ready and alarm outputs.
// - decode pulse+direction, forward/reverse trains or quadrature by format.
// - invert bit reverses count direction.
// - smoothing constant zero bypasses the command filter.
// - nonzero constant: first-order filter, time constant in 0.1 ms steps.
// - each step scaled by first numerator over denominator, 1 to 32767.
// - dynamic gearing only when its enable is 1, else first ratio.
// - dynamic gearing with gear select low uses second numerator.
// - second ratio shares denominator, numerator 1 to 32767.
// - gear ratio switches live, no stop needed.
// - position loop gain held, 0 to 1000, default 50.
// - feed-forward gain held in percent, 0 to 100.
// - feed-forward term smoothed with time constant in ms.
// - position error limit held, units of 100 pulses, default 400.
// - one bit selects treatment of the prohibit input.
// - prohibit select 1 ignores the prohibit input.
// - four-bit input function word held, default 0000.
// - function word 0001 enables the drive internally.
`timescale 1ns/1ps
`include "servo_cmd_cfg.svh"
module servo_pulse_position_command
    import servo_cmd_pkg::*;
#(
    parameter int CMD_TICK = `CMD_TICK_CYC,
    parameter int FF_TICK  = `FF_TICK_CYC
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // io connector pins, receiver outputs
    input  wire logic        pulse_i,
    input  wire logic        sign_i,
    input  wire logic        enable_i,
    input  wire logic        prohibit_i,
    input  wire logic        gear_sel_i,
    // drive outputs
    output logic             servo_ready_o,
    output logic             servo_alarm_o,
    output logic [31:0]      pos_cmd_o,
    output logic [23:0]      ff_term_o
);

    // ================================================================
    // pin synchronisers
    logic [4:0] pin_m_r;
    logic [4:0] pin_s_r;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_m_r <= 5'h00;
            pin_s_r <= 5'h00;
        end else begin
            pin_m_r <= {gear_sel_i, prohibit_i, enable_i, sign_i, pulse_i};
            pin_s_r <= pin_m_r;
        end
    end
    wire pulse_s    = pin_s_r[0];
    wire sign_s     = pin_s_r[1];
    wire enable_s   = pin_s_r[2];
    wire prohibit_s = pin_s_r[3];
    wire gear_sel_s = pin_s_r[4];

    // ================================================================
    // registers
    logic [4:0]  mode_cfg_r;
    logic [14:0] gear_num1_r;
    logic [14:0] gear_den_r;
    logic [14:0] gear_num2_r;
    logic [14:0] cmd_smooth_r;
    logic [9:0]  pos_gain_r;
    logic [6:0]  ff_gain_r;
    logic [9:0]  ff_smooth_r;
    logic [14:0] err_limit_r;
    logic [3:0]  func_word_r;

    wire        setup   = psel & ~penable;
    wire        wr_acc  = psel & penable & pwrite;
    wire [31:0] wd      = pwdata;
    wire        gear_ok = (wd[31:15] == 17'h00000) && (wd[14:0] != 15'h0000);
    wire        sel_cfg = paddr == `OFS_MODE_CFG;
    wire        sel_n1  = paddr == `OFS_GEAR_NUM1;
    wire        sel_den = paddr == `OFS_GEAR_DEN;
    wire        sel_n2  = paddr == `OFS_GEAR_NUM2;
    wire        sel_cs  = paddr == `OFS_CMD_SMOOTH;
    wire        sel_pg  = paddr == `OFS_POS_GAIN;
    wire        sel_fg  = paddr == `OFS_FF_GAIN;
    wire        sel_fs  = paddr == `OFS_FF_SMOOTH;
    wire        sel_el  = paddr == `OFS_ERR_LIMIT;
    wire        sel_fw  = paddr == `OFS_FUNC_WORD;
    wire        sel_st  = paddr == `OFS_STATUS;
    wire        sel_pc  = paddr == `OFS_POS_CMD;
    // out of range values are refused whole and flagged
    wire        bad_val = sel_cfg ? (wd[31:5] != 27'h0 || wd[1:0] == 2'b11) :
                          (sel_n1 | sel_den | sel_n2) ? !gear_ok :
                          sel_cs ? (wd[31:15] != 17'h0 || wd[14:0] > `MAX_SMOOTH) :
                          sel_pg ? (wd[31:10] != 22'h0 || wd[9:0] > `MAX_POS_GAIN) :
                          sel_fg ? (wd[31:7] != 25'h0 || wd[6:0] > `MAX_FF_GAIN) :
                          sel_fs ? (wd[31:10] != 22'h0 || wd[9:0] > `MAX_FF_SMOOTH) :
                          sel_el ? (wd[31:15] != 17'h0 || wd[14:0] > `MAX_SMOOTH) :
                          sel_fw ? (wd[31:4] != 28'h0) : 1'b0;
    wire        mapped  = sel_cfg | sel_n1 | sel_den | sel_n2 | sel_cs | sel_pg | sel_fg
                        | sel_fs | sel_el | sel_fw | sel_st | sel_pc;
    wire        ro_reg  = sel_st | sel_pc;
    wire        wr_ok   = wr_acc & mapped & ~ro_reg & ~bad_val;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & (~mapped | (pwrite & (ro_reg | bad_val)));

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_cfg_r   <= 5'h00;
            gear_num1_r  <= `RST_GEAR;
            gear_den_r   <= `RST_GEAR;
            gear_num2_r  <= `RST_GEAR;
            cmd_smooth_r <= 15'h0000;
            pos_gain_r   <= `RST_POS_GAIN;
            ff_gain_r    <= 7'h00;
            ff_smooth_r  <= 10'h000;
            err_limit_r  <= `RST_ERR_LIMIT;
            func_word_r  <= 4'h0;
        end else if (wr_ok) begin
            if (sel_cfg) mode_cfg_r   <= wd[4:0];
            if (sel_n1)  gear_num1_r  <= wd[14:0];
            if (sel_den) gear_den_r   <= wd[14:0];
            if (sel_n2)  gear_num2_r  <= wd[14:0];
            if (sel_cs)  cmd_smooth_r <= wd[14:0];
            if (sel_pg)  pos_gain_r   <= wd[9:0];
            if (sel_fg)  ff_gain_r    <= wd[6:0];
            if (sel_fs)  ff_smooth_r  <= wd[9:0];
            if (sel_el)  err_limit_r  <= wd[14:0];
            if (sel_fw)  func_word_r  <= wd[3:0];
        end
    end

    // ================================================================
    // drive enable and prohibit
    wire prohibit_sel = mode_cfg_r[`BIT_PROHIBIT_SEL];
    wire prohibit_eff = prohibit_s & ~prohibit_sel;
    wire enable_eff   = enable_s | func_word_r[`BIT_INT_ENABLE];
    wire ready_nxt    = enable_eff & ~prohibit_eff;
    logic ready_r;
    logic alarm_r;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_r <= 1'b0;
            alarm_r <= 1'b0;
        end else begin
            ready_r <= ready_nxt;
            alarm_r <= enable_eff & prohibit_eff;
        end
    end
    assign servo_ready_o = ready_r;
    assign servo_alarm_o = alarm_r;

    // ================================================================
    // pulse decoding
    logic dec_step;
    logic dec_dir;
    pulse_decode u_decode (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .fmt_i    (pulse_fmt_t'(mode_cfg_r[1:0])),
        .invert_i (mode_cfg_r[`BIT_INVERT]),
        .pulse_i  (pulse_s),
        .sign_i   (sign_s),
        .step_o   (dec_step),
        .dir_o    (dec_dir)
    );

    // ================================================================
    // electronic gear: residual accumulates numerator, drains by denominator
    wire               dyn_en   = mode_cfg_r[`BIT_DYN_GEAR];
    wire               use_n2   = dyn_en & ~gear_sel_s;
    wire        [14:0] num_sel  = use_n2 ? gear_num2_r : gear_num1_r;
    wire signed [23:0] num_s    = signed'({9'h000, num_sel});
    wire signed [23:0] den_s    = signed'({9'h000, gear_den_r});
    logic signed [23:0] gear_res_r;
    logic signed [31:0] gear_pos_r;
    wire               cnt_step = dec_step & ready_r;
    wire               g_up     = gear_res_r >= den_s;
    wire               g_dn     = gear_res_r <= -den_s;
    wire signed [23:0] g_add    = !cnt_step ? 24'sh000000 : (dec_dir ? -num_s : num_s);
    wire signed [23:0] g_sub    = g_up ? den_s : (g_dn ? -den_s : 24'sh000000);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gear_res_r <= 24'sh000000;
            gear_pos_r <= 32'sh00000000;
        end else begin
            gear_res_r <= gear_res_r + g_add - g_sub;
            if (g_up)      gear_pos_r <= gear_pos_r + 32'sh00000001;
            else if (g_dn) gear_pos_r <= gear_pos_r - 32'sh00000001;
        end
    end

    // ================================================================
    // tick dividers for 0.1 ms and 1 ms
    logic [15:0] cmd_div_r;
    logic [15:0] ff_div_r;
    wire cmd_tick = cmd_div_r == 16'(CMD_TICK - 1);
    wire ff_tick  = ff_div_r == 16'(FF_TICK - 1);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_div_r <= 16'h0000;
            ff_div_r  <= 16'h0000;
        end else begin
            cmd_div_r <= cmd_tick ? 16'h0000 : cmd_div_r + 16'h0001;
            ff_div_r  <= ff_tick ? 16'h0000 : ff_div_r + 16'h0001;
        end
    end

    // ================================================================
    // command smoothing: error added per tick, one unit released per
    // constant worth of accumulated error, giving a first-order lag
    logic signed [39:0] filt_frac_r;
    logic signed [31:0] filt_pos_r;
    wire               bypass    = cmd_smooth_r == 15'h0000;
    wire signed [39:0] tc_s      = signed'({25'h0000000, cmd_smooth_r});
    wire signed [39:0] lag       = 40'(gear_pos_r - filt_pos_r);
    wire               f_up      = filt_frac_r >= tc_s;
    wire               f_dn      = filt_frac_r <= -tc_s;
    wire signed [39:0] f_add     = cmd_tick ? lag : 40'sh0000000000;
    wire signed [39:0] f_sub     = f_up ? tc_s : (f_dn ? -tc_s : 40'sh0000000000);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            filt_frac_r <= 40'sh0000000000;
            filt_pos_r  <= 32'sh00000000;
        end else if (bypass) begin
            filt_frac_r <= 40'sh0000000000;
            filt_pos_r  <= gear_pos_r;
        end else begin
            filt_frac_r <= filt_frac_r + f_add - f_sub;
            if (f_up)      filt_pos_r <= filt_pos_r + 32'sh00000001;
            else if (f_dn) filt_pos_r <= filt_pos_r - 32'sh00000001;
        end
    end
    assign pos_cmd_o = filt_pos_r;

    // ================================================================
    // feed-forward: command steps per ms times gain in percent, smoothed
    logic signed [15:0] vel_cnt_r;
    logic signed [23:0] ff_raw_r;
    logic signed [31:0] ff_frac_r;
    logic signed [23:0] ff_out_r;
    logic signed [31:0] filt_pos_d_r;
    wire  signed [15:0] d_pos   = 16'(filt_pos_r - filt_pos_d_r);
    wire  signed [31:0] ftc_s   = signed'({22'h000000, ff_smooth_r});
    wire                ff_byp  = ff_smooth_r == 10'h000;
    wire                q_up    = ff_frac_r >= ftc_s;
    wire                q_dn    = ff_frac_r <= -ftc_s;
    wire  signed [31:0] q_add   = ff_tick ? 32'(ff_raw_r - ff_out_r) : 32'sh00000000;
    wire  signed [31:0] q_sub   = q_up ? ftc_s : (q_dn ? -ftc_s : 32'sh00000000);
    wire  signed [23:0] ff_prod = 24'(vel_cnt_r) * 24'(signed'({1'b0, ff_gain_r}));
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            filt_pos_d_r <= 32'sh00000000;
            vel_cnt_r    <= 16'sh0000;
            ff_raw_r     <= 24'sh000000;
            ff_frac_r    <= 32'sh00000000;
            ff_out_r     <= 24'sh000000;
        end else begin
            filt_pos_d_r <= filt_pos_r;
            vel_cnt_r    <= ff_tick ? d_pos : vel_cnt_r + d_pos;
            if (ff_tick) ff_raw_r <= ff_prod;
            if (ff_byp) begin
                ff_frac_r <= 32'sh00000000;
                ff_out_r  <= ff_raw_r;
            end else begin
                ff_frac_r <= ff_frac_r + q_add - q_sub;
                if (q_up)      ff_out_r <= ff_out_r + 24'sh000001;
                else if (q_dn) ff_out_r <= ff_out_r - 24'sh000001;
            end
        end
    end
    assign ff_term_o = ff_out_r;

    // ================================================================
    // read data, captured in the setup phase
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            if (sel_cfg)     prdata <= {27'h0, mode_cfg_r};
            else if (sel_n1) prdata <= {17'h0, gear_num1_r};
            else if (sel_den) prdata <= {17'h0, gear_den_r};
            else if (sel_n2) prdata <= {17'h0, gear_num2_r};
            else if (sel_cs) prdata <= {17'h0, cmd_smooth_r};
            else if (sel_pg) prdata <= {22'h0, pos_gain_r};
            else if (sel_fg) prdata <= {25'h0, ff_gain_r};
            else if (sel_fs) prdata <= {22'h0, ff_smooth_r};
            else if (sel_el) prdata <= {17'h0, err_limit_r};
            else if (sel_fw) prdata <= {28'h0, func_word_r};
            else if (sel_st) prdata <= {28'h0, use_n2, dec_dir, alarm_r, ready_r};
            else if (sel_pc) prdata <= filt_pos_r;
            else             prdata <= 32'h00000000;
        end
    end

    // ================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_bypass;
        bypass && $past(bypass) |-> filt_pos_r == $past(gear_pos_r);
    endproperty
    a_bypass: assert property (p_bypass) else $error("filter not bypassed");

    property p_filter_lag;
        !bypass && f_up |=> filt_pos_r == $past(filt_pos_r) + 32'sh00000001;
    endproperty
    a_filter_lag: assert property (p_filter_lag) else $error("filter step missing");

    property p_gear_out;
        g_up ##1 1'b1 |-> gear_pos_r == $past(gear_pos_r) + 32'sh00000001;
    endproperty
    a_gear_out: assert property (p_gear_out) else $error("gear output step missing");

    property p_first_ratio;
        !dyn_en |-> num_sel == gear_num1_r;
    endproperty
    a_first_ratio: assert property (p_first_ratio) else $error("second ratio used");

    property p_second_ratio;
        dyn_en && !gear_sel_s && cnt_step && !dec_dir && !g_up && !g_dn
            |=> gear_res_r == $past(gear_res_r) + signed'({9'h000, $past(gear_num2_r)});
    endproperty
    a_second_ratio: assert property (p_second_ratio) else $error("second numerator missed");

    property p_num_range;
        gear_num2_r != 15'h0000 && gear_num1_r != 15'h0000 && gear_den_r != 15'h0000;
    endproperty
    a_num_range: assert property (p_num_range) else $error("gear term zero");

    property p_gain_range;
        pos_gain_r <= `MAX_POS_GAIN && ff_gain_r <= `MAX_FF_GAIN;
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain out of range");

    property p_prohibit_ignored;
        prohibit_sel && enable_eff ##1 1'b1 |-> servo_ready_o && !servo_alarm_o;
    endproperty
    a_prohibit_ignored: assert property (p_prohibit_ignored) else $error("prohibit not ignored");

    property p_internal_enable;
        func_word_r[`BIT_INT_ENABLE] && !prohibit_eff |=> servo_ready_o;
    endproperty
    a_internal_enable: assert property (p_internal_enable) else $error("internal enable failed");

    c_gear_switch: cover property (dyn_en ##1 $fell(gear_sel_s) ##[1:20] cnt_step);
    c_filter_run:  cover property (!bypass && f_up);
    c_bus_error:   cover property (pslverr);
    c_ff_move:     cover property (!ff_byp && q_up);

endmodule : servo_pulse_position_command

// File: host_pulse_gen.sv
// host controller model: drives the pulse and sign pair receiver outputs
// assumes send is entered right after a rising clock edge
`timescale 1ns/1ps
module host_pulse_gen (
    // clock
    input  wire logic clk_i,
    // pulse and sign lines
    output logic      pulse_o,
    output logic      sign_o
);
    logic [1:0] q_r;
    initial begin
        pulse_o = 1'b0;
        sign_o  = 1'b0;
        q_r     = 2'h0;
    end
    // =============================================================
    // line sequencing, each level stands four clocks
    task automatic hold4();
        repeat (4) @(posedge clk_i);
    endtask : hold4
    task automatic send(input int n, input logic [1:0] fmt, input logic rev);
        for (int k = 0; k < n; k++) begin
            if (fmt == 2'h2) begin
                q_r = rev ? q_r - 2'h1 : q_r + 2'h1;
                pulse_o <= (q_r == 2'h1) || (q_r == 2'h2);
                sign_o  <= q_r[1];
                hold4();
            end else if (fmt == 2'h1 && rev) begin
                sign_o <= 1'b1;
                hold4();
                sign_o <= 1'b0;
                hold4();
            end else begin
                sign_o <= rev & (fmt == 2'h0);
                hold4();
                pulse_o <= 1'b1;
                hold4();
                pulse_o <= 1'b0;
                hold4();
            end
        end
    endtask : send
endmodule : host_pulse_gen

// File: servo_pulse_position_command_tb_top.sv
// testbench: apb register access and pulse traffic against expectations
// assumes the host_pulse_gen model and the design's zero wait apb slave
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module servo_pulse_position_command_tb_top;
    logic        clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, pos_cmd_o;
    logic        pready, pslverr, pulse_w, sign_w, rdy, alm;
    logic        enable_i = 1'b0, prohibit_i = 1'b0, gear_sel_i = 1'b1;
    logic [23:0] ff_w;
    int          error_cnt = 0, num_checks = 0;
    always #25 clk_i = ~clk_i;
    host_pulse_gen host_pulse_gen_i (.clk_i(clk_i), .pulse_o(pulse_w), .sign_o(sign_w));
    servo_pulse_position_command #(.CMD_TICK(10), .FF_TICK(50))
    servo_pulse_position_command_i (.clk_i(clk_i), .rstn_i(rstn_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_i(pulse_w),
        .sign_i(sign_w), .enable_i(enable_i), .prohibit_i(prohibit_i),
        .gear_sel_i(gear_sel_i), .servo_ready_o(rdy), .servo_alarm_o(alm),
        .pos_cmd_o(pos_cmd_o), .ff_term_o(ff_w));
    // =============================================================
    // apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] er, input logic ee);
        int i;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        i = 0;
        do begin @(posedge clk_i); i++; end while (pready !== 1'b1 && i < 100);
        if (i == 100) begin error_cnt++; print_verdict(); end
        if (!w) `CHK(prdata, er)
        `CHK(pslverr, ee)
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    task automatic settle(input logic [31:0] e);
        int i;
        i = 0;
        while (pos_cmd_o !== e && i < 3000) begin @(posedge clk_i); i++; end
        `CHK(pos_cmd_o, e)
    endtask : settle
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    // =============================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        apb(0, 8'h14, 0, 32'h32, 0);
        apb(0, 8'h20, 0, 32'h190, 0);
        apb(0, 8'h0C, 0, 32'h1, 0);
        apb(0, 8'h30, 0, 32'h0, 1);
        apb(1, 8'h14, 32'h3E9, 0, 1);
        apb(0, 8'h14, 0, 32'h32, 0);
        apb(1, 8'h18, 32'h65, 0, 1);
        apb(1, 8'h1C, 32'h3E9, 0, 1);
        apb(1, 8'h04, 32'h0, 0, 1);
        apb(1, 8'h24, 32'h1, 0, 0);
        repeat (5) @(posedge clk_i);
        `CHK(rdy, 1'b1)
        apb(1, 8'h04, 32'h5, 0, 0);
        apb(1, 8'h08, 32'h3, 0, 0);
        host_pulse_gen_i.send(3, 2'h0, 0); settle(32'h5);
        host_pulse_gen_i.send(3, 2'h0, 1); settle(32'h0);
        apb(1, 8'h00, 32'h4, 0, 0);
        host_pulse_gen_i.send(3, 2'h0, 0); settle(32'hFFFFFFFB);
        apb(1, 8'h00, 32'h8, 0, 0);
        apb(1, 8'h0C, 32'h2, 0, 0);
        gear_sel_i <= 1'b0;
        host_pulse_gen_i.send(3, 2'h0, 0); settle(32'hFFFFFFFD);
        gear_sel_i <= 1'b1;
        host_pulse_gen_i.send(3, 2'h0, 0); settle(32'h2);
        apb(1, 8'h04, 32'h3, 0, 0);
        apb(1, 8'h00, 32'h1, 0, 0);
        host_pulse_gen_i.send(2, 2'h1, 0); settle(32'h4);
        host_pulse_gen_i.send(2, 2'h1, 1); settle(32'h2);
        apb(1, 8'h00, 32'h2, 0, 0);
        apb(1, 8'h18, 32'h64, 0, 0);
        // one step per 4 clocks: a 50 clock window holds 12 or 13 steps
        fork
            host_pulse_gen_i.send(40, 2'h2, 0);
            begin
                repeat (120) @(posedge clk_i);
                `CHK(ff_w == 24'h0004B0 || ff_w == 24'h000514, 1'b1)
            end
        join
        settle(32'h2A);
        host_pulse_gen_i.send(40, 2'h2, 1); settle(32'h2);
        apb(1, 8'h00, 32'h0, 0, 0);
        apb(1, 8'h10, 32'h5, 0, 0);
        host_pulse_gen_i.send(3, 2'h0, 0); settle(32'h5);
        prohibit_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        `CHK({rdy, alm}, 2'b01)
        apb(1, 8'h00, 32'h10, 0, 0);
        repeat (5) @(posedge clk_i);
        `CHK({rdy, alm}, 2'b10)
        print_verdict();
    end
endmodule : servo_pulse_position_command_tb_top
